//--- bench/panel_model.sv
// Operator panel, wiring and motor feedback stand-in
module panel_model
(
   input  wire logic clk_i,
   output logic [3:0] btn_o,
   output logic       forced_stop_o,
   output logic       servo_on_o,
   output logic       link_ok_o,
   output logic       step_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // stop wiring closed, servo off before any mode
   initial begin
      btn_o = 4'h0;
      forced_stop_o = 1'b1;
      servo_on_o = 1'b0;
      link_ok_o = 1'b1;
      step_o = 1'b0;
   end
   task automatic hold(input int b, input logic v);
      @(posedge clk_i);
      btn_o[b] <= v;
   endtask
   task automatic press(input int b, input int n);
      hold(b, 1'b1);
      repeat (n) @(posedge clk_i);
      btn_o[b] <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic lines(input logic fs, input logic servo_on_input, input logic lk);
      @(posedge clk_i);
      forced_stop_o <= fs;
      servo_on_o <= servo_on_input;
      link_ok_o <= lk;
   endtask
   // Gap of zero is a prompt motor, larger is a slow one
   task automatic step(input int n, input int g);
      repeat (n) begin
         @(posedge clk_i);
         step_o <= 1'b1;
         @(posedge clk_i);
         step_o <= 1'b0;
         repeat (g) @(posedge clk_i);
      end
   endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the test operation sequencer
module tb_top
   import test_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, fs, servo_on_input, lk, stp, s_rdy, s_zero;
   logic        ext_cmd = 1'b0;
   logic        ext_fwd = 1'b0;
   logic        ext_rev = 1'b0;
   logic [3:0]  btn, scr;
   logic [1:0]  dir, sty;
   logic [15:0] spd, acc;
   logic [4:0]  mode;
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          n, i;
   always #5 clk_i = ~clk_i;
   panel_model pm_u (.clk_i(clk_i), .btn_o(btn), .forced_stop_o(fs), .servo_on_o(servo_on_input),
      .link_ok_o(lk), .step_o(stp));
   test_op_sequencer dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .btn_up_i(btn[0]), .btn_down_i(btn[1]),
      .btn_mode_i(btn[2]), .btn_set_i(btn[3]), .forced_stop_input_i(fs),
      .servo_on_input_i(servo_on_input), .ext_cmd_active_i(ext_cmd), .link_ok_i(lk),
      .ext_fwd_i(ext_fwd), .ext_rev_i(ext_rev), .pulse_step_i(stp), .motion_dir_o(dir),
      .motion_speed_o(spd), .motion_accel_o(acc), .stop_style_o(sty), .screen_o(scr),
      .mode_o(mode), .sim_ready_o(s_rdy), .sim_zero_speed_o(s_zero));
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge clk_i);
      #1;
   endtask
   task automatic do_reset();
      sys_rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Whole run needs a few hundred cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      void'($urandom(32'h0ff8_c310));
      do_reset();
      settle(1);
      check("speed", SPEED_RST, spd);
      check("accel", ACCEL_RST, acc);
      check("mode", ST_IDLE, mode);
      apb(1'b0, DIST_OFS, 0);
      check("dist", DIST_RST, rd);
      apb(1'b1, ACCEL_OFS, 60000);
      apb(1'b0, ACCEL_OFS, 0);
      check("accel_cap", ACCEL_MAX, rd);
      n = $urandom_range(50000);
      apb(1'b1, ACCEL_OFS, n);
      settle(2);
      check("accel_out", n, acc);
      apb(1'b0, 8'h1C, 0);
      check("unmapped_err", 1, err);
      check("unmapped_data", 0, rd);
      n = $urandom_range(8, 3);
      apb(1'b1, DIST_OFS, n);
      apb(1'b1, CTRL_OFS, 4);
      settle(3);
      check("mode", ST_POS, mode);
      apb(1'b1, CMD_OFS, 1);
      settle(2);
      check("dir", DIR_CCW, dir);
      pm_u.step(2, 0);
      apb(1'b1, CMD_OFS, 4);
      settle(2);
      check("dir", DIR_STOP, dir);
      apb(1'b0, REMAIN_OFS, 0);
      check("remain", n - 2, rd);
      pm_u.press(2, 3);
      settle(2);
      check("screen", 1, scr);
      apb(1'b1, CMD_OFS, 1);
      settle(2);
      check("dir", DIR_CCW, dir);
      pm_u.step(n - 2, $urandom_range(3));
      settle(2);
      check("dir", DIR_STOP, dir);
      apb(1'b1, CMD_OFS, 2);
      settle(2);
      check("dir", DIR_STOP, dir);
      apb(1'b1, CTRL_OFS, 0);
      settle(3);
      apb(1'b1, CTRL_OFS, 4);
      settle(3);
      apb(1'b1, CMD_OFS, 2);
      settle(2);
      check("dir", DIR_CW, dir);
      pm_u.lines(1'b1, 1'b0, 1'b0);
      // Abrupt style is shown only in the cycle the move is dropped
      settle(1);
      check("dir", DIR_STOP, dir);
      check("style", STOP_ABRUPT, sty);
      pm_u.lines(1'b1, 1'b0, 1'b1);
      do_reset();
      ext_cmd <= 1'b1;
      apb(1'b1, CTRL_OFS, 2);
      settle(3);
      check("mode", ST_IDLE, mode);
      @(posedge clk_i);
      ext_cmd <= 1'b0;
      settle(3);
      check("mode", ST_JOG, mode);
      for (i = 0; i < 2; i++) begin
         pm_u.hold(i, 1'b1);
         settle(2);
         check("dir", i ? DIR_CW : DIR_CCW, dir);
         pm_u.hold(i, 1'b0);
         settle(2);
         check("dir", DIR_STOP, dir);
      end
      for (i = 1; i <= 9; i++) begin
         pm_u.press(2, 2);
         settle(2);
         check("screen", i % 9, scr);
         pm_u.press(i % 2, 2);
         settle(1);
         check("screen", i % 9, scr);
      end
      pm_u.lines(1'b0, 1'b0, 1'b1);
      pm_u.hold(0, 1'b1);
      settle(2);
      check("dir", DIR_STOP, dir);
      pm_u.lines(1'b1, 1'b0, 1'b1);
      apb(1'b1, CTRL_OFS, 3);
      pm_u.lines(1'b1, 1'b0, 1'b0);
      settle(2);
      check("style", STOP_RAMP, sty);
      pm_u.hold(0, 1'b0);
      do_reset();
      pm_u.lines(1'b1, 1'b1, 1'b1);
      apb(1'b1, CTRL_OFS, 8);
      settle(3);
      check("mode", ST_IDLE, mode);
      pm_u.lines(1'b1, 1'b0, 1'b1);
      settle(3);
      check("mode", ST_MLESS, mode);
      pm_u.lines(1'b1, 1'b1, 1'b1);
      ext_fwd <= 1'b1;
      settle(3);
      check("sim_zero", 0, s_zero);
      check("sim_ready", 1, s_rdy);
      @(posedge clk_i);
      ext_rev <= 1'b1;
      settle(2);
      check("sim_zero_both", 1, s_zero);
      apb(1'b1, CTRL_OFS, 0);
      pm_u.press(3, 5);
      settle(2);
      check("mode", ST_MLESS, mode);
      conclude();
   end
endmodule

//--- bench/test_seq_chk.sv
// Port-level assertions for the test operation sequencer
module test_seq_chk
   import test_seq_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        btn_up_i,
   input wire logic        btn_down_i,
   input wire logic        btn_mode_i,
   input wire logic        btn_set_i,
   input wire logic        forced_stop_input_i,
   input wire logic        servo_on_input_i,
   input wire logic        ext_cmd_active_i,
   input wire logic        link_ok_i,
   input wire logic [1:0]  motion_dir_o,
   input wire logic [15:0] motion_accel_o,
   input wire logic [1:0]  stop_style_o,
   input wire logic [3:0]  screen_o,
   input wire logic [4:0]  mode_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic run_ok;
   logic jog;
   // Link state only matters for stops, so runs are judged with it good
   assign run_ok = forced_stop_input_i && link_ok_i && !ext_cmd_active_i;
   assign jog = mode_o == ST_JOG;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   chk_ready_access: assert property ((psel && !penable) ##1 (psel && penable) |-> pready)
      else $error("pready absent in first access cycle");
   chk_err_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside an access cycle");
   // Mode port lags the state by one cycle, so the gate input is one cycle older
   chk_jog_blocked: assert property (!jog && $past(ext_cmd_active_i) |=> !jog)
      else $error("jog entered with external command present");
   chk_pos_blocked: assert property (mode_o != ST_POS && $past(ext_cmd_active_i) |=> mode_o != ST_POS)
      else $error("positioning entered with external command present");
   chk_stop_holds: assert property (
      !forced_stop_input_i && motion_dir_o == DIR_STOP && mode_o != ST_MLESS |=> motion_dir_o == DIR_STOP)
      else $error("run started while forced stop open");
   chk_up_ccw: assert property (jog && run_ok && btn_up_i && !btn_down_i |=> motion_dir_o == DIR_CCW || !jog)
      else $error("up button did not run CCW");
   chk_down_cw: assert property (jog && run_ok && btn_down_i && !btn_up_i |=> motion_dir_o == DIR_CW || !jog)
      else $error("down button did not run CW");
   chk_accel_cap: assert property (motion_accel_o <= ACCEL_MAX)
      else $error("time constant above its ceiling");
   chk_pos_abrupt: assert property (
      mode_o == ST_POS && motion_dir_o != DIR_STOP && !link_ok_i |=> motion_dir_o == DIR_STOP && stop_style_o == STOP_ABRUPT)
      else $error("positioning link loss not an abrupt stop");
   chk_screen_keep: assert property (
      (btn_up_i || btn_down_i) && !btn_mode_i && !btn_set_i && !(psel && pwrite) |=> $stable(screen_o))
      else $error("up or down changed the screen");
   chk_mless_gate: assert property ($past(servo_on_input_i) && mode_o != ST_MLESS |=> mode_o != ST_MLESS)
      else $error("motor-less entered with servo on");
   chk_mless_stay: assert property (mode_o == ST_MLESS |=> mode_o == ST_MLESS)
      else $error("motor-less mode left without power cycle");
endmodule

bind test_op_sequencer test_seq_chk chk_u (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .btn_up_i(btn_up_i), .btn_down_i(btn_down_i),
   .btn_mode_i(btn_mode_i), .btn_set_i(btn_set_i), .forced_stop_input_i(forced_stop_input_i),
   .servo_on_input_i(servo_on_input_i), .ext_cmd_active_i(ext_cmd_active_i),
   .link_ok_i(link_ok_i), .motion_dir_o(motion_dir_o), .motion_accel_o(motion_accel_o),
   .stop_style_o(stop_style_o), .screen_o(screen_o), .mode_o(mode_o)
);

//--- common/test_seq_pkg.sv
// Constants for the test operation sequencer
package test_seq_pkg;
   // APB register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] SPEED_OFS  = 8'h04;
   localparam logic [7:0] ACCEL_OFS  = 8'h08;
   localparam logic [7:0] DIST_OFS   = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [7:0] REMAIN_OFS = 8'h14;
   localparam logic [7:0] CMD_OFS    = 8'h18;
   // CMD register bits (write pulses)
   localparam int CMD_FWD_BIT   = 0;
   localparam int CMD_REV_BIT   = 1;
   localparam int CMD_PAUSE_BIT = 2;
   // CTRL register bits
   localparam int CTRL_PC_LINK_BIT  = 0;
   localparam int CTRL_JOG_SEL_BIT  = 1;
   localparam int CTRL_POS_SEL_BIT  = 2;
   localparam int CTRL_MLESS_SEL_BIT = 3;
   // Reset values and write ceilings
   localparam logic [15:0] SPEED_RST = 16'h00C8;
   localparam logic [15:0] ACCEL_RST = 16'h03E8;
   localparam logic [15:0] ACCEL_MAX = 16'hC350;
   localparam logic [23:0] DIST_RST  = 24'h00_2710;
   localparam logic [23:0] DIST_MAX  = 24'h98_967F;
   // Timing
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned TICK_HZ       = 1_000;
   localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
   localparam int unsigned SET_HOLD_S    = 2;
   localparam int unsigned SET_HOLD_TICKS = SET_HOLD_S * TICK_HZ;
   localparam int unsigned STATUS_SCREENS = 8;
   // Motion direction codes
   localparam logic [1:0] DIR_STOP = 2'h0;
   localparam logic [1:0] DIR_CCW  = 2'h1;
   localparam logic [1:0] DIR_CW   = 2'h2;
   // Stop style codes
   localparam logic [1:0] STOP_NONE   = 2'h0;
   localparam logic [1:0] STOP_RAMP   = 2'h1;
   localparam logic [1:0] STOP_ABRUPT = 2'h2;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_JOG   = 5'b00010,
      ST_POS   = 5'b00100,
      ST_MLESS = 5'b01000,
      ST_EXIT  = 5'b10000
   } mode_e;
endpackage

//--- rtl/hold_timer.sv
// Button hold timer on a 1 ms tick
module hold_timer
   import test_seq_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic tick_i,
   input  wire logic hold_i,
   output logic      done_o
);
   logic [11:0] cnt_ff;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_ff <= 12'h000;
      end else if (!hold_i) begin
         cnt_ff <= 12'h000;
      end else if (tick_i && cnt_ff < 12'(SET_HOLD_TICKS)) begin
         cnt_ff <= cnt_ff + 12'h001;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= hold_i && (cnt_ff >= 12'(SET_HOLD_TICKS));
      end
   end
endmodule

//--- rtl/test_op_sequencer.sv
// Test operation sequencer: jog, single positioning, motor-less
//
// The APB interface to the registers and the address map were chosen for this implementation.
module test_op_sequencer
   import test_seq_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        btn_up_i,
   input  wire logic        btn_down_i,
   input  wire logic        btn_mode_i,
   input  wire logic        btn_set_i,
   input  wire logic        forced_stop_input_i,
   input  wire logic        servo_on_input_i,
   input  wire logic        ext_cmd_active_i,
   input  wire logic        link_ok_i,
   input  wire logic        ext_fwd_i,
   input  wire logic        ext_rev_i,
   input  wire logic        pulse_step_i,
   output logic [1:0]       motion_dir_o,
   output logic [15:0]      motion_speed_o,
   output logic [15:0]      motion_accel_o,
   output logic [1:0]       stop_style_o,
   output logic [3:0]       screen_o,
   output logic [4:0]       mode_o,
   output logic             sim_ready_o,
   output logic             sim_zero_speed_o
);
   logic [15:0] speed_ff;
   logic [15:0] accel_ff;
   logic [23:0] dist_ff;
   logic [23:0] remain_ff;
   logic [3:0]  ctrl_ff;
   logic [2:0]  cmd_pulse_ff;
   logic        paused_ff;
   logic [1:0]  pos_dir_ff;
   logic        pos_done_ff;
   logic [16:0] div_ff;
   logic        tick_ff;
   logic        mode_q_ff;
   logic        set_done;
   mode_e       state_ff;
   mode_e       nxt_state;
   logic [1:0]  nxt_dir;
   logic [1:0]  nxt_stop;

   wire wr_en   = psel && penable && pwrite;
   wire rd_en   = psel && penable && !pwrite;
   wire mode_pr = btn_mode_i && !mode_q_ff;
   // Active low forced stop: high means connected, motion allowed
   wire run_ok  = forced_stop_input_i;
   wire pc_link = ctrl_ff[CTRL_PC_LINK_BIT];

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == CTRL_OFS) || (a == SPEED_OFS) || (a == ACCEL_OFS) ||
                (a == DIST_OFS) || (a == STATUS_OFS) || (a == REMAIN_OFS) ||
                (a == CMD_OFS);
   endfunction

   // One millisecond tick for hold timing
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_ff  <= 17'h0_0000;
         tick_ff <= 1'b0;
      end else if (div_ff == 17'(TICK_DIV - 1)) begin
         div_ff  <= 17'h0_0000;
         tick_ff <= 1'b1;
      end else begin
         div_ff  <= div_ff + 17'h0_0001;
         tick_ff <= 1'b0;
      end
   end

   hold_timer u_hold (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .tick_i    (tick_ff),
      .hold_i    (btn_set_i && (screen_o == 4'h1) && state_ff == ST_JOG),
      .done_o    (set_done)
   );

   // APB single-cycle access phase, zero wait states
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok(paddr);
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         speed_ff <= SPEED_RST;
         accel_ff <= ACCEL_RST;
         dist_ff  <= DIST_RST;
         ctrl_ff  <= 4'h0;
      end else if (wr_en && pready) begin
         unique case (paddr)
            CTRL_OFS:  ctrl_ff  <= pwdata[3:0];
            SPEED_OFS: speed_ff <= pwdata[15:0];
            ACCEL_OFS: accel_ff <= (pwdata[15:0] > ACCEL_MAX) ? ACCEL_MAX : pwdata[15:0];
            DIST_OFS:  dist_ff  <= (pwdata[23:0] > DIST_MAX) ? DIST_MAX : pwdata[23:0];
            default: ;
         endcase
      end
   end

   // Command register writes are one-cycle pulses
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmd_pulse_ff <= 3'h0;
      end else if (wr_en && pready && paddr == CMD_OFS) begin
         cmd_pulse_ff <= pwdata[2:0];
      end else begin
         cmd_pulse_ff <= 3'h0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            CTRL_OFS:   prdata <= {28'h000_0000, ctrl_ff};
            SPEED_OFS:  prdata <= {16'h0000, speed_ff};
            ACCEL_OFS:  prdata <= {16'h0000, accel_ff};
            DIST_OFS:   prdata <= {8'h00, dist_ff};
            STATUS_OFS: prdata <= {16'h0000, paused_ff, pos_done_ff, stop_style_o,
                                   motion_dir_o, screen_o, 1'b0, state_ff};
            REMAIN_OFS: prdata <= {8'h00, remain_ff};
            default:    prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Mode transitions
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (ctrl_ff[CTRL_MLESS_SEL_BIT] && !servo_on_input_i) begin
               nxt_state = ST_MLESS;
            end else if (ctrl_ff[CTRL_JOG_SEL_BIT] && !ext_cmd_active_i) begin
               nxt_state = ST_JOG;
            end else if (ctrl_ff[CTRL_POS_SEL_BIT] && !ext_cmd_active_i) begin
               nxt_state = ST_POS;
            end
         end
         ST_JOG: begin
            if (set_done) begin
               nxt_state = ST_EXIT;
            end
         end
         ST_POS: begin
            if (!ctrl_ff[CTRL_POS_SEL_BIT]) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_MLESS: nxt_state = ST_MLESS;
         ST_EXIT: begin
            if (!btn_set_i) begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Status screen stepping on mode press
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_q_ff <= 1'b0;
         screen_o  <= 4'h0;
      end else begin
         mode_q_ff <= btn_mode_i;
         if (state_ff != nxt_state) begin
            screen_o <= 4'h0;
         // step, wrap to ready; up/down ignored
         end else if (mode_pr) begin
            screen_o <= (screen_o == 4'(STATUS_SCREENS)) ? 4'h0 : screen_o + 4'h1;
         end
      end
   end

   // Positioning: remaining distance, pause and completion
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         remain_ff   <= 24'h00_0000;
         paused_ff   <= 1'b0;
         pos_dir_ff  <= DIR_STOP;
         pos_done_ff <= 1'b0;
      end else if (state_ff != ST_POS) begin
         remain_ff   <= 24'h00_0000;
         paused_ff   <= 1'b0;
         pos_dir_ff  <= DIR_STOP;
         pos_done_ff <= 1'b0;
      end else if (pos_dir_ff != DIR_STOP && !link_ok_i) begin
         pos_dir_ff  <= DIR_STOP;
         remain_ff   <= 24'h00_0000;
         pos_done_ff <= 1'b1;
      end else if (cmd_pulse_ff[CMD_PAUSE_BIT]) begin
         if (paused_ff) begin
            remain_ff  <= 24'h00_0000;
            pos_dir_ff <= DIR_STOP;
            paused_ff  <= 1'b0;
            pos_done_ff <= 1'b1;
         end else if (pos_dir_ff != DIR_STOP) begin
            paused_ff <= 1'b1;
         end
      end else if (cmd_pulse_ff[CMD_FWD_BIT] || cmd_pulse_ff[CMD_REV_BIT]) begin
         if (paused_ff) begin
            if ((pos_dir_ff == DIR_CCW && cmd_pulse_ff[CMD_FWD_BIT]) ||
                (pos_dir_ff == DIR_CW && cmd_pulse_ff[CMD_REV_BIT])) begin
               paused_ff <= 1'b0;
            end
         end else if (!pos_done_ff && pos_dir_ff == DIR_STOP && run_ok &&
                      !ext_cmd_active_i && dist_ff != 24'h00_0000) begin
            remain_ff  <= dist_ff;
            pos_dir_ff <= cmd_pulse_ff[CMD_FWD_BIT] ? DIR_CCW : DIR_CW;
         end
      end else if (pos_dir_ff != DIR_STOP && !paused_ff && pulse_step_i) begin
         if (remain_ff == 24'h00_0001) begin
            pos_dir_ff  <= DIR_STOP;
            pos_done_ff <= 1'b1;
         end
         remain_ff <= remain_ff - 24'h00_0001;
      end
   end

   // Motion request selection
   always_comb begin
      nxt_dir  = DIR_STOP;
      nxt_stop = STOP_NONE;
      unique case (state_ff)
         ST_JOG: begin
            if (pc_link && !link_ok_i) begin
               nxt_stop = STOP_RAMP;
            end else if (run_ok && !ext_cmd_active_i) begin
               // up is CCW; down is CW
               if (btn_up_i && !btn_down_i) begin
                  nxt_dir = DIR_CCW;
               end else if (btn_down_i && !btn_up_i) begin
                  nxt_dir = DIR_CW;
               end
            end
         end
         ST_POS: begin
            if (pos_dir_ff != DIR_STOP && !link_ok_i) begin
               nxt_stop = STOP_ABRUPT;
            end else if (!run_ok) begin
               nxt_stop = STOP_ABRUPT;
            end else if (!paused_ff) begin
               nxt_dir = pos_dir_ff;
            end
         end
         ST_MLESS: begin
            if (ext_fwd_i && !ext_rev_i) begin
               nxt_dir = DIR_CCW;
            end else if (ext_rev_i && !ext_fwd_i) begin
               nxt_dir = DIR_CW;
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         motion_dir_o     <= DIR_STOP;
         stop_style_o     <= STOP_NONE;
         motion_speed_o   <= SPEED_RST;
         motion_accel_o   <= ACCEL_RST;
         mode_o           <= ST_IDLE;
         sim_ready_o      <= 1'b0;
         sim_zero_speed_o <= 1'b1;
      end else begin
         // Motor-less never drives the real motor
         motion_dir_o     <= (state_ff == ST_MLESS) ? DIR_STOP : nxt_dir;
         stop_style_o     <= nxt_stop;
         motion_speed_o   <= speed_ff;
         motion_accel_o   <= accel_ff;
         mode_o           <= state_ff;
         sim_ready_o      <= (state_ff == ST_MLESS) && servo_on_input_i && run_ok;
         sim_zero_speed_o <= (state_ff != ST_MLESS) || nxt_dir == DIR_STOP ||
                             speed_ff == 16'h0000;
      end
   end
endmodule
